// ===== core/adc_conversion_sequencer.sv
// Purpose: control, timing and result logic of the converter
// Assumes: converter core takes a sample strobe and returns data on conv_done
// Notes: injection arbitration and wait-for-read buffering are not built
// Functional notes
// [RULE1] trigger select bits 13:12, reset 01
// [RULE2] busy bit 8 set while active
// [RULE3] start samples, converts, stores, requests interrupt
// [RULE4] mode field bits 6:5 selects four modes
// [RULE5] single modes: hardware clears start bit
// [RULE6] continuous modes: hardware never clears start
// [RULE7] fixed continuous stop ends after conversion
// [RULE8] scan continuous stop ends after channel 0
// [RULE9] clear then set restarts with fresh settings
// [RULE10] channel field: fixed channel or scan top
// [RULE11] channel change waits for conversion or round
// [RULE12] mode change waits for conversion end
// [RULE13] sample flag high only while sampling
// [RULE14] calibration disable bit 4 suppresses calibration
// [RULE15] resolution field 13:12: 00 ten, 01 eight
// [RULE16] conversion clock divides by field plus one
// [RULE17] sample time is 4 times field plus one
// [RULE18] standard results to main result register
// [RULE19] injected channel number written only by software
// [RULE20] result alignment by layout and resolution
// [RULE21] injected register: channel 15:12, value 11:0
// [RULE22] bit 15 selects enhanced layout
// [RULE23] done flag set after every standard conversion
// [RULE24] scan descends from programmed channel to 0
// [RULE25] software write beats hardware start update
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
    parameter int chan_w = 4,
    parameter int data_w = 10
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic conv_done,
    input wire logic [data_w-1:0] conv_data,
    output logic [chan_w-1:0] mux_channel,
    output logic sample_strobe,
    output logic sample_active,
    output logic calibration_active,
    output logic conversion_done_irq_flag,
    output logic [1:0] injection_trigger_source,
    output logic injection_enable,
    output logic wait_for_read_enable
);
    adc_seq_pkg::seq_state_t state_q;
    logic [15:0] ctrl_q;
    logic [15:0] timing_q;
    logic [15:0] result_q;
    logic [15:0] inj_q;
    logic [chan_w-1:0] chan_q;
    logic [1:0] mode_q;
    logic [chan_w-1:0] top_q;
    logic [6:0] div_q;
    logic [8:0] step_q;
    logic [8:0] step_lim;
    logic bc_tick;
    logic wr_ctrl;
    logic restart;
    logic sw_stop;
    logic finish;
    logic last_conv;
    logic [15:0] placed;

    function automatic logic [15:0] place_result(input logic enh, input logic [1:0] res,
        input logic [data_w-1:0] d, input logic [chan_w-1:0] ch);
        logic [11:0] v;
        v = 12'h000;
        if (res == adc_seq_pkg::res_8bit)
            v = enh ? {d[data_w-1 -: 8], 4'h0} : {2'h0, d[data_w-1 -: 8], 2'h0}; // [RULE20]
        else
            v = enh ? {d, 2'h0} : {2'h0, d}; // [RULE20]
        place_result = {ch, v};
    endfunction

    assign wr_ctrl = reg_wr && (reg_addr == adc_seq_pkg::main_control_off);
    assign restart = wr_ctrl && reg_wdata[adc_seq_pkg::start_bit]; // [RULE9]
    assign sw_stop = !ctrl_q[adc_seq_pkg::start_bit];
    assign last_conv = (chan_q == '0) || !mode_q[1];
    // single modes end after the unit; continuous ones end only when stopped
    assign finish = conv_done && (state_q == adc_seq_pkg::st_convert)
        && (mode_q[1] ? (chan_q == '0) : 1'b1)
        && (!mode_q[0] || sw_stop); // [RULE5] [RULE7] [RULE8]

    // conversion clock divider, field value plus one
    always_ff @(posedge sys_clk)
    begin
        // realign per phase so every sample phase gets its full length
        if (sys_rst || restart || state_q == adc_seq_pkg::st_idle
            || state_q == adc_seq_pkg::st_convert)
            div_q <= '0; // [RULE17]
        else if (div_q >= {1'b0, timing_q[adc_seq_pkg::ctc_lsb +: 6]})
            div_q <= '0; // [RULE16]
        else
            div_q <= div_q + 7'd1;
    end
    assign bc_tick = (state_q != adc_seq_pkg::st_idle)
        && (div_q >= {1'b0, timing_q[adc_seq_pkg::ctc_lsb +: 6]}); // [RULE16]

    always_comb
    begin
        // nine bits: field 63 gives 256 ticks
        step_lim = 9'(adc_seq_pkg::sample_mult)
            * ({3'b000, timing_q[adc_seq_pkg::stc_lsb +: 6]} + 9'd1); // [RULE17]
        if (state_q == adc_seq_pkg::st_cal)
            step_lim = 9'(adc_seq_pkg::cal_steps);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q <= adc_seq_pkg::st_idle;
            step_q <= '0;
            chan_q <= '0;
            mode_q <= '0;
            top_q <= '0;
        end
        else if (restart)
        begin
            // abort and reload everything from the registers
            mode_q <= reg_wdata[adc_seq_pkg::mode_lsb +: 2]; // [RULE9] [RULE4]
            chan_q <= reg_wdata[chan_w-1:0]; // [RULE10]
            top_q <= reg_wdata[chan_w-1:0];
            step_q <= '0;
            state_q <= reg_wdata[adc_seq_pkg::calibration_disable_bit] ? adc_seq_pkg::st_sample
                : adc_seq_pkg::st_cal; // [RULE14]
        end
        else
        begin
            case (state_q)
                adc_seq_pkg::st_idle:
                    step_q <= '0;
                adc_seq_pkg::st_cal, adc_seq_pkg::st_sample:
                begin
                    if (bc_tick && step_q + 9'd1 >= step_lim)
                    begin
                        step_q <= '0;
                        state_q <= (state_q == adc_seq_pkg::st_cal) ? adc_seq_pkg::st_sample
                            : adc_seq_pkg::st_convert; // [RULE13] [RULE17]
                    end
                    else if (bc_tick)
                        step_q <= step_q + 9'd1;
                end
                adc_seq_pkg::st_convert:
                begin
                    if (finish)
                        state_q <= adc_seq_pkg::st_idle;
                    else if (conv_done)
                    begin
                        state_q <= adc_seq_pkg::st_sample;
                        // new mode after each conversion, channel after unit
                        mode_q <= ctrl_q[adc_seq_pkg::mode_lsb +: 2]; // [RULE12]
                        if (last_conv)
                        begin
                            chan_q <= ctrl_q[chan_w-1:0]; // [RULE11] [RULE10]
                            top_q <= ctrl_q[chan_w-1:0];
                        end
                        else
                            chan_q <= chan_q - 1'b1; // [RULE24]
                    end
                end
                default:
                    state_q <= adc_seq_pkg::st_idle;
            endcase
        end
    end

    // control register; software write wins over hardware clear
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ctrl_q <= adc_seq_pkg::main_control_rst; // [RULE1]
        else if (wr_ctrl)
            ctrl_q <= reg_wdata; // [RULE25]
        else if (finish && !mode_q[0])
            ctrl_q[adc_seq_pkg::start_bit] <= 1'b0; // [RULE5] [RULE6]
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            timing_q <= adc_seq_pkg::timing_control_rst; // [RULE15]
        else if (reg_wr && reg_addr == adc_seq_pkg::timing_control_off)
            timing_q <= reg_wdata;
    end

    assign placed = place_result(ctrl_q[adc_seq_pkg::layout_bit],
        timing_q[adc_seq_pkg::res_lsb +: 2], conv_data, chan_q); // [RULE22]

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            result_q <= '0;
        else if (state_q == adc_seq_pkg::st_convert && conv_done)
            result_q <= placed; // [RULE3] [RULE18]
    end

    // converter never loads the injected channel number
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            inj_q <= adc_seq_pkg::injected_result_rst;
        else if (reg_wr && reg_addr == adc_seq_pkg::injected_result_off)
            inj_q <= reg_wdata; // [RULE19] [RULE21]
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            conversion_done_irq_flag <= 1'b0;
        else
            conversion_done_irq_flag <= (state_q == adc_seq_pkg::st_convert)
                && conv_done; // [RULE23] [RULE3]
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                adc_seq_pkg::main_control_off:
                begin
                    reg_rdata <= ctrl_q;
                    reg_rdata[adc_seq_pkg::busy_bit] <= state_q != adc_seq_pkg::st_idle; // [RULE2]
                    reg_rdata[adc_seq_pkg::sample_bit] <= sample_active; // [RULE13]
                end
                adc_seq_pkg::timing_control_off: reg_rdata <= timing_q;
                adc_seq_pkg::main_result_off: reg_rdata <= result_q;
                adc_seq_pkg::injected_result_off: reg_rdata <= inj_q;
                adc_seq_pkg::core_status_off: reg_rdata <= {12'h000, top_q};
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    assign sample_active = state_q == adc_seq_pkg::st_sample; // [RULE13]
    assign calibration_active = state_q == adc_seq_pkg::st_cal; // [RULE14]
    assign sample_strobe = (state_q == adc_seq_pkg::st_sample) && bc_tick
        && (step_q + 9'd1 >= step_lim);
    assign mux_channel = chan_q; // [RULE24]
    assign injection_trigger_source = ctrl_q[adc_seq_pkg::trig_lsb +: 2]; // [RULE1]
    assign injection_enable = ctrl_q[10];
    assign wait_for_read_enable = ctrl_q[9];
endmodule

// ===== core/adc_seq_pkg.sv
// Purpose: constants shared by the converter sequencer
// Assumes: 16-bit registers on a plain word-indexed port
// Notes: offsets are word indices on the register port
package adc_seq_pkg;
    localparam logic [15:0] main_result_off = 16'h0000;
    localparam logic [15:0] injected_result_off = 16'hf0a0;
    localparam logic [15:0] main_control_off = 16'h0002;
    localparam logic [15:0] timing_control_off = 16'h0004;
    localparam logic [15:0] core_status_off = 16'h0006;
    localparam logic [15:0] main_control_rst = 16'h1000;
    localparam logic [15:0] timing_control_rst = 16'h0000;
    localparam logic [15:0] injected_result_rst = 16'h0000;
    localparam int layout_bit = 15;
    localparam int sample_bit = 14;
    localparam int trig_lsb = 12;
    localparam int busy_bit = 8;
    localparam int start_bit = 7;
    localparam int mode_lsb = 5;
    localparam int calibration_disable_bit = 4;
    localparam int res_lsb = 12;
    localparam int ctc_lsb = 6;
    localparam int stc_lsb = 0;
    localparam logic [1:0] trig_rst = 2'h1;
    localparam logic [1:0] mode_fix_single = 2'h0;
    localparam logic [1:0] mode_fix_cont = 2'h1;
    localparam logic [1:0] mode_scan_single = 2'h2;
    localparam logic [1:0] mode_scan_cont = 2'h3;
    localparam logic [1:0] res_10bit = 2'h0;
    localparam logic [1:0] res_8bit = 2'h1;
    localparam logic [7:0] sample_mult = 8'h04;
    localparam logic [7:0] conv_steps_10 = 8'h0c;
    localparam logic [7:0] conv_steps_8 = 8'h0a;
    localparam logic [7:0] cal_steps = 8'h10;
    typedef enum logic [1:0] {st_idle = 2'b00, st_sample = 2'b01, st_convert = 2'b11,
        st_cal = 2'b10} seq_state_t;
endpackage

// ===== verif/adc_seq_properties.sv
// Purpose: port checks of the converter sequencer
// Assumes: core answers within eight cycles of a sample strobe
// Notes: a register write may abort a phase, so it excuses some checks
`timescale 1ns/1ps
module adc_seq_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic conv_done,
    input wire logic sample_strobe,
    input wire logic sample_active,
    input wire logic calibration_active,
    input wire logic conversion_done_irq_flag,
    input wire logic [1:0] injection_trigger_source
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_ctl_rd;
        reg_rd && reg_addr == adc_seq_pkg::main_control_off;
    endsequence
    sequence s_answer;
        ##[1:8] (conversion_done_irq_flag || reg_wr);
    endsequence
    trig_reset_a: assert property ($fell(sys_rst) |-> injection_trigger_source == 2'h1)
        else $error("trigger source not 01 after reset");
    flags_apart_a: assert property (!(sample_active && calibration_active))
        else $error("sample and calibration together");
    strobe_ends_a: assert property (sample_strobe && !reg_wr |=> !sample_active)
        else $error("sampling went on past the strobe");
    irq_cause_a: assert property (conversion_done_irq_flag |-> $past(conv_done))
        else $error("done flag without a core result");
    cal_first_a: assert property (
        $fell(calibration_active) && !$past(reg_wr) |-> sample_active)
        else $error("calibration not followed by sampling");
    answer_in_a: assert property (sample_strobe |-> s_answer)
        else $error("no result within eight cycles");
    status_read_a: assert property (s_ctl_rd |=>
        reg_rdata[14] == $past(sample_active)
        && (reg_rdata[8] || !$past(sample_active || calibration_active)))
        else $error("status bits disagree with phase");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the answer cycle");
endmodule
bind adc_conversion_sequencer adc_seq_properties chk (.sys_clk, .sys_rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .conv_done, .sample_strobe, .sample_active, .calibration_active,
    .conversion_done_irq_flag, .injection_trigger_source);

// ===== verif/adc_core_model.sv
// Purpose: converter core model behind the channel multiplexer
// Assumes: one conversion per sample strobe
// Notes: data lines scramble outside the done pulse
`timescale 1ns/1ps
module adc_core_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sample_strobe,
    input wire logic slow,
    input wire logic [9:0] next_data,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [2:0] wait_q;
    logic [9:0] held_q;
    always_ff @(posedge sys_clk)
    begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (sys_rst)
        begin
            wait_q <= 3'h0;
            conv_data <= 10'h000;
        end
        else if (sample_strobe)
        begin
            // a new strobe drops any result still pending
            wait_q <= slow ? 3'h6 : 3'h1;
            held_q <= next_data;
        end
        else if (wait_q != 3'h0)
        begin
            wait_q <= wait_q - 3'h1;
            conv_done <= wait_q == 3'h1;
            if (wait_q == 3'h1)
                conv_data <= held_q;
        end
    end
endmodule

// ===== verif/adc_conversion_sequencer_tb.sv
// Purpose: random and corner runs of the converter sequencer
// Assumes: core model answers after each sample strobe
// Notes: scan tops kept low to bound run time
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
    logic sys_clk, sys_rst, reg_wr, reg_rd, conv_done, slow, sample_strobe, sample_active;
    logic calibration_active, conversion_done_irq_flag, injection_enable, wait_for_read_enable;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, v, inj;
    logic [9:0] conv_data, next_data;
    logic [3:0] mux_channel;
    logic [1:0] injection_trigger_source;
    int miscompares, tests_run, nirq, slen, clen, last_s, last_c, seed;
    adc_conversion_sequencer dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .conv_done, .conv_data, .mux_channel, .sample_strobe,
        .sample_active, .calibration_active, .conversion_done_irq_flag,
        .injection_trigger_source, .injection_enable, .wait_for_read_enable);
    adc_core_model core (.sys_clk, .sys_rst, .sample_strobe, .slow, .next_data,
        .conv_done, .conv_data);
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk)
    begin
        if (conversion_done_irq_flag === 1'b1) nirq <= nirq + 1;
        slen <= sample_active === 1'b1 ? slen + 1 : 0;
        if (slen != 0 && sample_active !== 1'b1) last_s <= slen;
        clen <= calibration_active === 1'b1 ? clen + 1 : 0;
        if (clen != 0 && calibration_active !== 1'b1) last_c <= clen;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (conversion_done_irq_flag !== 1'b1 && k < 400)
        begin
            @(posedge sys_clk);
            #1 k++;
        end
        chk("done flag", 16'h0001, {15'h0, k < 400});
    endtask
    function automatic logic [11:0] place(input logic lay, input logic res, input logic [9:0] d);
        if (lay)
            return res ? {d[9:2], 4'h0} : {d, 2'h0};
        return res ? {2'h0, d[9:2], 2'h0} : {2'h0, d};
    endfunction
    task automatic run(input logic [2:0] i);
        logic [15:0] c;
        logic [3:0] ch;
        int n, n0, ctc, stc;
        ctc = 1 + {$random(seed)} % 2;
        stc = 1 + {$random(seed)} % 2;
        // scan tops from 1 up, so a stop always lands inside a round
        ch = i[1] ? 4'(1 + {$random(seed)} % 3) : 4'($random(seed));
        n = i[1] ? ch + 1 : 1 + i[0];
        next_data <= 10'($random(seed));
        slow <= 1'($random(seed));
        c = {i[2], 7'h0, 1'b1, i[1:0], i != 3'h1, ch};
        wr(adc_seq_pkg::timing_control_off, {3'h0, i[0], 6'(ctc), 6'(stc)});
        last_c = 0;
        n0 = nirq;
        wr(adc_seq_pkg::main_control_off, c);
        #1 chk("channel", {12'h0, ch}, {12'h0, mux_channel});
        for (int j = 0; j < n; j++)
        begin
            wait_irq();
            rd(adc_seq_pkg::main_result_off);
            chk("result", {i[1] ? ch - j[3:0] : ch, place(i[2], i[0], next_data)}, v);
            if (j == 0 && i[0])
            begin
                rd(adc_seq_pkg::main_control_off);
                chk("start held", 16'h0080, v & 16'h0080);
                wr(adc_seq_pkg::main_control_off, c & 16'hff7f);
            end
        end
        repeat (150) @(posedge sys_clk);
        chk("conversions", 16'(n0 + n), 16'(nirq));
        rd(adc_seq_pkg::main_control_off);
        chk("idle", 16'h0000, v & 16'h0180);
        chk("sample time", 16'(4 * (stc + 1) * (ctc + 1)), 16'(last_s));
        chk("calibration", 16'(i == 3'h1 ? 16 * (ctc + 1) : 0), 16'(last_c));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        seed = 67930;
        {sys_rst, reg_wr, reg_rd, slow} = 4'h8;
        {reg_addr, reg_wdata, next_data} = 42'h0;
        {miscompares, tests_run, nirq, slen, clen, last_s, last_c} = 224'h0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(adc_seq_pkg::main_control_off);
        chk("control reset", 16'h1000, v);
        rd(adc_seq_pkg::timing_control_off);
        chk("timing reset", 16'h0000, v);
        rd(16'h0010);
        chk("unmapped", 16'h0000, v);
        chk("trigger port", 16'h0001, {14'h0, injection_trigger_source});
        chk("injection ports", 16'h0000, {14'h0, injection_enable, wait_for_read_enable});
        rd(adc_seq_pkg::injected_result_off);
        chk("injected reset", 16'h0000, v);
        inj = 16'($random(seed));
        wr(adc_seq_pkg::injected_result_off, inj);
        for (int i = 0; i < 8; i++)
            run(3'(i));
        wr(adc_seq_pkg::timing_control_off, 16'h0041);
        wr(adc_seq_pkg::main_control_off, 16'h00b5);
        wait_irq();
        wr(adc_seq_pkg::main_control_off, 16'h0039);
        wr(adc_seq_pkg::main_control_off, 16'h0099);
        wait_irq();
        rd(adc_seq_pkg::main_result_off);
        chk("restart result", {6'h24, next_data}, v);
        rd(adc_seq_pkg::injected_result_off);
        chk("injected kept", inj, v);
        end_sim();
    end
endmodule
